// ===== core/iep_slice.sv
// Interrupt enable group four and priority groups zero to four, behind an APB slave.
// Assumes peripheral requests and foreign enables come from logic on pclk, so no
// synchroniser is placed on them; arbitration and vectoring sit outside this block.
//
// Notes on behaviour
// [RULE_01] Bit 3 of the group-four enable register enables the checksum generator request.
// [RULE_02] Bit 2 of the group-four enable register enables the second serial port error request.
// [RULE_03] Bit 1 of the group-four enable register enables the first serial port error request.
// [RULE_04] An enable bit at one passes its request to arbitration and at zero blocks it.
// [RULE_05] Unused bits of every register here ignore writes and read as zero.
// [RULE_06] A priority field of all ones gives its source level seven, the highest.
// [RULE_07] Priority values one to seven map straight to levels one to seven, one lowest.
// [RULE_08] A priority field of zero disables its source whatever its enable says.
// [RULE_09] After reset every implemented priority field reads as level four.
// [RULE_10] After reset the implemented group-four enable bits read as zero.
// [RULE_11] Priority group zero holds timer one, compare one, capture one, external zero.
// [RULE_12] Priority group one holds timer two, compare two, capture two; low nibble unused.
// [RULE_13] Priority group two holds serial one receive, port one event, fault, timer three.
// [RULE_14] Priority group three holds converter done and serial one transmit; 15-7 unused.
// [RULE_15] Priority group four holds pin change, comparator, two-wire master and slave.
// [RULE_16] Each source's enable and level go to arbitration; active needs both nonzero.
//
// Design decisions made here: the APB register port and the register addresses.

`timescale 1ns/1ps

module iep_slice (
  input  wire logic            pclk,            // APB clock, 40 MHz.
  input  wire logic            presetn,         // Asynchronous reset, active low.
  input  wire logic            psel,            // APB select.
  input  wire logic            penable,         // APB access phase.
  input  wire logic            pwrite,          // APB direction, high for write.
  input  wire logic [11:0]     paddr,           // APB byte address.
  input  wire logic [31:0]     pwdata,          // APB write data.
  input  wire logic [3:0]      pstrb,           // APB write byte strobes.
  output logic      [31:0]     prdata,          // APB read data, registered.
  output logic                 pready,          // APB ready, always high.
  output logic                 pslverr,         // APB error on unmapped address.
  input  wire logic [2:0]      en4_req,         // Raw requests of the group-four sources.
  output iep_pkg::iep_en4_t    en4_bits,        // Group-four enable bits to arbitration.
  output logic      [2:0]      en4_req_gated,   // Group-four requests after enables.
  input  wire iep_pkg::iep_src_t src_en,        // Enables of prioritised sources.
  input  wire iep_pkg::iep_src_t src_req,       // Raw requests of prioritised sources.
  output iep_pkg::iep_prio_t   src_prio,        // Priority levels to arbitration.
  output iep_pkg::iep_src_t    src_active       // Requests both enabled and level nonzero.
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------

  // Merge a 16-bit write under byte strobes and a writable mask.
  function automatic logic [15:0] merge(input logic [15:0] old_val,
      input logic [31:0] wdata,
      input logic [3:0]  strb,
      input logic [15:0] mask);
    logic [15:0] lanes;
    lanes = {{8{strb[1]}}, {8{strb[0]}}} & mask;
    merge = (old_val & ~lanes) | (wdata[15:0] & lanes);
  endfunction

  // Extract the 3-bit priority field at a nibble position.
  function automatic logic [2:0] fld(input logic [15:0] r, input int pos);
    fld = r[pos +: 3];
  endfunction

  // A request counts only when enabled and its level is not the off code.
  function automatic logic live(input logic req, input logic en, input logic [2:0] lvl);
    live = req & en & (lvl != iep_pkg::IEP_LEVEL_OFF);
  endfunction

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  logic        setup;
  logic        access;
  logic        mapped;
  logic [15:0] enable_group4;
  logic [15:0] prio_group0;
  logic [15:0] prio_group1;
  logic [15:0] prio_group2;
  logic [15:0] prio_group3;
  logic [15:0] prio_group4;
  logic [15:0] next_rdata;

  // Zero wait states: every access completes in its first access cycle.
  assign pready = 1'b1;
  assign setup  = psel & ~penable;
  assign access = psel & penable;

  // Address decode and read mux; reserved bits already hold zero.
  always_comb begin
    mapped     = 1'b1;
    next_rdata = 16'h0000;
    case (paddr)
      iep_pkg::IEP_OFS_ENABLE_GROUP4: next_rdata = enable_group4;
      iep_pkg::IEP_OFS_PRIO_GROUP0:   next_rdata = prio_group0;
      iep_pkg::IEP_OFS_PRIO_GROUP1:   next_rdata = prio_group1;
      iep_pkg::IEP_OFS_PRIO_GROUP2:   next_rdata = prio_group2;
      iep_pkg::IEP_OFS_PRIO_GROUP3:   next_rdata = prio_group3;
      iep_pkg::IEP_OFS_PRIO_GROUP4:   next_rdata = prio_group4;
      default:                        mapped = 1'b0;
    endcase
  end

  // Error answer only in the access phase, so it never leaks into idle cycles.
  assign pslverr = access & ~mapped;

  // Read data is captured in the setup cycle so it comes from a flip-flop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata <= {16'h0000, next_rdata};
    end
  end

  // ----------------------------------------------------------------------
  // Enable register, group four
  // ----------------------------------------------------------------------
  logic wr_hit;
  assign wr_hit = access & pwrite & pready;

  // Only bits 3 to 1 are writable; the mask keeps the rest at zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_group4 <= iep_pkg::IEP_RST_ENABLE_GROUP4; // RULE_10
    end else if (wr_hit && paddr == iep_pkg::IEP_OFS_ENABLE_GROUP4) begin
      enable_group4 <= merge(enable_group4, pwdata, pstrb,
                             iep_pkg::IEP_MASK_ENABLE_GROUP4); // RULE_05
    end
  end

  // ----------------------------------------------------------------------
  // Priority registers
  // ----------------------------------------------------------------------

  // Group zero: timer one, compare one, capture one, external interrupt zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prio_group0 <= iep_pkg::IEP_RST_PRIO_GROUP0; // RULE_09
    end else if (wr_hit && paddr == iep_pkg::IEP_OFS_PRIO_GROUP0) begin
      prio_group0 <= merge(prio_group0, pwdata, pstrb, iep_pkg::IEP_MASK_PRIO_GROUP0); // RULE_11
    end
  end

  // Group one: the low nibble is unused and stays zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prio_group1 <= iep_pkg::IEP_RST_PRIO_GROUP1; // RULE_09
    end else if (wr_hit && paddr == iep_pkg::IEP_OFS_PRIO_GROUP1) begin
      prio_group1 <= merge(prio_group1, pwdata, pstrb, iep_pkg::IEP_MASK_PRIO_GROUP1); // RULE_12
    end
  end

  // Group two: serial one receive, port one event and fault, timer three.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prio_group2 <= iep_pkg::IEP_RST_PRIO_GROUP2; // RULE_09
    end else if (wr_hit && paddr == iep_pkg::IEP_OFS_PRIO_GROUP2) begin
      prio_group2 <= merge(prio_group2, pwdata, pstrb, iep_pkg::IEP_MASK_PRIO_GROUP2); // RULE_13
    end
  end

  // Group three: only the low byte carries fields.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prio_group3 <= iep_pkg::IEP_RST_PRIO_GROUP3; // RULE_09
    end else if (wr_hit && paddr == iep_pkg::IEP_OFS_PRIO_GROUP3) begin
      prio_group3 <= merge(prio_group3, pwdata, pstrb, iep_pkg::IEP_MASK_PRIO_GROUP3); // RULE_14
    end
  end

  // Group four: pin change, comparator, two-wire master and slave.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prio_group4 <= iep_pkg::IEP_RST_PRIO_GROUP4; // RULE_09
    end else if (wr_hit && paddr == iep_pkg::IEP_OFS_PRIO_GROUP4) begin
      prio_group4 <= merge(prio_group4, pwdata, pstrb, iep_pkg::IEP_MASK_PRIO_GROUP4); // RULE_15
    end
  end

  // ----------------------------------------------------------------------
  // Hand-off to arbitration
  // ----------------------------------------------------------------------
  iep_pkg::iep_prio_t prio_now;

  // Levels are the raw field values: one lowest, seven highest, zero off.
  always_comb begin
    prio_now.timer_one_prio        = fld(prio_group0, iep_pkg::IEP_POS_FLD_HI); // RULE_06
    prio_now.compare_one_prio      = fld(prio_group0, iep_pkg::IEP_POS_FLD_MH); // RULE_07
    prio_now.capture_one_prio      = fld(prio_group0, iep_pkg::IEP_POS_FLD_ML);
    prio_now.ext_irq_zero_prio     = fld(prio_group0, iep_pkg::IEP_POS_FLD_LO);
    prio_now.timer_two_prio        = fld(prio_group1, iep_pkg::IEP_POS_FLD_HI);
    prio_now.compare_two_prio      = fld(prio_group1, iep_pkg::IEP_POS_FLD_MH);
    prio_now.capture_two_prio      = fld(prio_group1, iep_pkg::IEP_POS_FLD_ML);
    prio_now.serial1_receive_prio  = fld(prio_group2, iep_pkg::IEP_POS_FLD_HI);
    prio_now.sync_port1_event_prio = fld(prio_group2, iep_pkg::IEP_POS_FLD_MH);
    prio_now.sync_port1_fault_prio = fld(prio_group2, iep_pkg::IEP_POS_FLD_ML);
    prio_now.timer_three_prio      = fld(prio_group2, iep_pkg::IEP_POS_FLD_LO);
    prio_now.converter_done_prio   = fld(prio_group3, iep_pkg::IEP_POS_FLD_ML);
    prio_now.serial1_transmit_prio = fld(prio_group3, iep_pkg::IEP_POS_FLD_LO);
    prio_now.pin_change_prio       = fld(prio_group4, iep_pkg::IEP_POS_FLD_HI);
    prio_now.comparator_prio       = fld(prio_group4, iep_pkg::IEP_POS_FLD_MH);
    prio_now.twowire1_master_prio  = fld(prio_group4, iep_pkg::IEP_POS_FLD_ML);
    prio_now.twowire1_slave_prio   = fld(prio_group4, iep_pkg::IEP_POS_FLD_LO);
  end

  // Levels and enables are registered: one cycle of latency buys clean outputs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_prio <= '0;
      en4_bits <= '0;
    end else begin
      src_prio                      <= prio_now; // RULE_16
      en4_bits.checksum_irq_en      <= enable_group4[iep_pkg::IEP_POS_CHECKSUM_EN]; // RULE_01
      en4_bits.serial2_error_irq_en <= enable_group4[iep_pkg::IEP_POS_SERIAL2_ERR]; // RULE_02
      en4_bits.serial1_error_irq_en <= enable_group4[iep_pkg::IEP_POS_SERIAL1_ERR]; // RULE_03
    end
  end

  // Group-four requests pass only while their enable bit is set.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en4_req_gated <= 3'h0;
    end else begin
      en4_req_gated <= en4_req & enable_group4[3:1]; // RULE_04
    end
  end

  // A zero level blocks the source even when enabled.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_active <= '0;
    end else begin
      src_active.timer_one        <= live(src_req.timer_one, src_en.timer_one,
        prio_now.timer_one_prio); // RULE_08
      src_active.compare_one      <= live(src_req.compare_one, src_en.compare_one,
        prio_now.compare_one_prio);
      src_active.capture_one      <= live(src_req.capture_one, src_en.capture_one,
        prio_now.capture_one_prio);
      src_active.ext_irq_zero     <= live(src_req.ext_irq_zero, src_en.ext_irq_zero,
        prio_now.ext_irq_zero_prio);
      src_active.timer_two        <= live(src_req.timer_two, src_en.timer_two,
        prio_now.timer_two_prio);
      src_active.compare_two      <= live(src_req.compare_two, src_en.compare_two,
        prio_now.compare_two_prio);
      src_active.capture_two      <= live(src_req.capture_two, src_en.capture_two,
        prio_now.capture_two_prio);
      src_active.serial1_receive  <= live(src_req.serial1_receive, src_en.serial1_receive,
        prio_now.serial1_receive_prio);
      src_active.sync_port1_event <= live(src_req.sync_port1_event, src_en.sync_port1_event,
        prio_now.sync_port1_event_prio);
      src_active.sync_port1_fault <= live(src_req.sync_port1_fault, src_en.sync_port1_fault,
        prio_now.sync_port1_fault_prio);
      src_active.timer_three      <= live(src_req.timer_three, src_en.timer_three,
        prio_now.timer_three_prio);
      src_active.converter_done   <= live(src_req.converter_done, src_en.converter_done,
        prio_now.converter_done_prio);
      src_active.serial1_transmit <= live(src_req.serial1_transmit, src_en.serial1_transmit,
        prio_now.serial1_transmit_prio);
      src_active.pin_change       <= live(src_req.pin_change, src_en.pin_change,
        prio_now.pin_change_prio);
      src_active.comparator       <= live(src_req.comparator, src_en.comparator,
        prio_now.comparator_prio);
      src_active.twowire1_master  <= live(src_req.twowire1_master, src_en.twowire1_master,
        prio_now.twowire1_master_prio);
      src_active.twowire1_slave   <= live(src_req.twowire1_slave, src_en.twowire1_slave,
        prio_now.twowire1_slave_prio);
    end
  end

endmodule // iep_slice

// ===== common/iep_pkg.sv
// Package for the interrupt enable and priority slice.
// Holds register offsets, write masks, reset values, field positions and carrier types.
// Assumes a 32-bit APB register bus with each 16-bit register in one aligned word.
package iep_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [11:0] IEP_OFS_ENABLE_GROUP4 = 12'h000;
  localparam logic [11:0] IEP_OFS_PRIO_GROUP0   = 12'h004;
  localparam logic [11:0] IEP_OFS_PRIO_GROUP1   = 12'h008;
  localparam logic [11:0] IEP_OFS_PRIO_GROUP2   = 12'h00c;
  localparam logic [11:0] IEP_OFS_PRIO_GROUP3   = 12'h010;
  localparam logic [11:0] IEP_OFS_PRIO_GROUP4   = 12'h014;

  // ----------------------------------------------------------------------
  // Writable bits of each register; all other bits read as zero
  // ----------------------------------------------------------------------
  localparam logic [15:0] IEP_MASK_ENABLE_GROUP4 = 16'h000e;
  localparam logic [15:0] IEP_MASK_PRIO_GROUP0   = 16'h7777;
  localparam logic [15:0] IEP_MASK_PRIO_GROUP1   = 16'h7770;
  localparam logic [15:0] IEP_MASK_PRIO_GROUP2   = 16'h7777;
  localparam logic [15:0] IEP_MASK_PRIO_GROUP3   = 16'h0077;
  localparam logic [15:0] IEP_MASK_PRIO_GROUP4   = 16'h7777;

  // ----------------------------------------------------------------------
  // Reset values: enables clear, every priority field at level four
  // ----------------------------------------------------------------------
  localparam logic [15:0] IEP_RST_ENABLE_GROUP4 = 16'h0000;
  localparam logic [15:0] IEP_RST_PRIO_GROUP0   = 16'h4444;
  localparam logic [15:0] IEP_RST_PRIO_GROUP1   = 16'h4440;
  localparam logic [15:0] IEP_RST_PRIO_GROUP2   = 16'h4444;
  localparam logic [15:0] IEP_RST_PRIO_GROUP3   = 16'h0044;
  localparam logic [15:0] IEP_RST_PRIO_GROUP4   = 16'h4444;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int IEP_POS_CHECKSUM_EN = 3;
  localparam int IEP_POS_SERIAL2_ERR = 2;
  localparam int IEP_POS_SERIAL1_ERR = 1;
  localparam int IEP_POS_FLD_HI      = 12;
  localparam int IEP_POS_FLD_MH      = 8;
  localparam int IEP_POS_FLD_ML      = 4;
  localparam int IEP_POS_FLD_LO      = 0;
  localparam logic [2:0] IEP_LEVEL_OFF = 3'h0;

  // ----------------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------------
  typedef logic [2:0] iep_level_t;

  // Priority levels handed to arbitration, one per source.
  typedef struct packed {
    iep_level_t timer_one_prio;
    iep_level_t compare_one_prio;
    iep_level_t capture_one_prio;
    iep_level_t ext_irq_zero_prio;
    iep_level_t timer_two_prio;
    iep_level_t compare_two_prio;
    iep_level_t capture_two_prio;
    iep_level_t serial1_receive_prio;
    iep_level_t sync_port1_event_prio;
    iep_level_t sync_port1_fault_prio;
    iep_level_t timer_three_prio;
    iep_level_t converter_done_prio;
    iep_level_t serial1_transmit_prio;
    iep_level_t pin_change_prio;
    iep_level_t comparator_prio;
    iep_level_t twowire1_master_prio;
    iep_level_t twowire1_slave_prio;
  } iep_prio_t;

  // One bit per prioritised source, same order as the priority struct.
  typedef struct packed {
    logic timer_one;
    logic compare_one;
    logic capture_one;
    logic ext_irq_zero;
    logic timer_two;
    logic compare_two;
    logic capture_two;
    logic serial1_receive;
    logic sync_port1_event;
    logic sync_port1_fault;
    logic timer_three;
    logic converter_done;
    logic serial1_transmit;
    logic pin_change;
    logic comparator;
    logic twowire1_master;
    logic twowire1_slave;
  } iep_src_t;

  // The three sources enabled by the group-four enable register.
  typedef struct packed {
    logic checksum_irq_en;
    logic serial2_error_irq_en;
    logic serial1_error_irq_en;
  } iep_en4_t;

endpackage

// ===== tb/iep_slice_monitor.sv
// Concurrent checks on the enable and priority slice.
// Sees only the slice ports; attached by the bind after the module.
`timescale 1ns/1ps
module iep_slice_monitor (
  input wire logic               pclk,          // Clock.
  input wire logic               presetn,       // Reset, active low.
  input wire logic               psel,          // Select.
  input wire logic               penable,       // Access phase.
  input wire logic               pwrite,        // Direction.
  input wire logic [11:0]        paddr,         // Address.
  input wire logic [31:0]        pwdata,        // Write data.
  input wire logic [3:0]         pstrb,         // Strobes.
  input wire logic [31:0]        prdata,        // Read data.
  input wire logic               pready,        // Ready.
  input wire logic               pslverr,       // Error.
  input wire logic [2:0]         en4_req,       // Raw requests.
  input wire iep_pkg::iep_en4_t  en4_bits,      // Enables out.
  input wire logic [2:0]         en4_req_gated, // Gated requests.
  input wire iep_pkg::iep_src_t  src_en,        // Enables in.
  input wire iep_pkg::iep_src_t  src_req,       // Requests in.
  input wire iep_pkg::iep_prio_t src_prio,      // Levels out.
  input wire iep_pkg::iep_src_t  src_active     // Active out.
);
  logic [16:0] lvl_nz;
  logic        seen;
  logic        wr;
  // Nonzero level per source, bit i matching field i of the level bus.
  always_comb begin
    for (int i = 0; i < 17; i++) begin
      lvl_nz[i] = |src_prio[3*i +: 3];
    end
  end
  assign wr = psel && penable && pwrite && pready;
  // Rises once after each release of reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen <= 1'b0;
    end else begin
      seen <= 1'b1;
    end
  end
  // Packs the four 3-bit fields of a priority word, highest first.
  function automatic logic [11:0] pk(input logic [31:0] d);
    return {d[14:12], d[10:8], d[6:4], d[2:0]};
  endfunction
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_GATE: assert property (en4_req_gated == ($past(en4_req) & en4_bits))
    else $error("gate wrong");
  AST_ACTIVE: assert property (src_active == ($past(src_req) & $past(src_en) & lvl_nz))
    else $error("active wrong");
  AST_RST_PRIO: assert property ($rose(seen) |-> src_prio == {17{3'h4}})
    else $error("reset levels");
  AST_RST_EN: assert property ($rose(seen) |-> en4_bits == 3'h0)
    else $error("reset enables");
  AST_WR_EN4: assert property (wr && paddr == iep_pkg::IEP_OFS_ENABLE_GROUP4 && pstrb[0]
    |-> ##2 en4_bits == $past(pwdata[3:1], 2)) else $error("enable write");
  AST_WR_P0: assert property (wr && paddr == iep_pkg::IEP_OFS_PRIO_GROUP0
    && pstrb[1:0] == 2'h3
    |-> ##2 src_prio[50:39] == pk($past(pwdata, 2))) else $error("group0 write");
  AST_WR_P3: assert property (wr && paddr == iep_pkg::IEP_OFS_PRIO_GROUP3 && pstrb[0]
    |-> ##2 src_prio[17:12] == 6'(pk($past(pwdata, 2)))) else $error("group3 write");
  AST_WR_P4: assert property (wr && paddr == iep_pkg::IEP_OFS_PRIO_GROUP4
    && pstrb[1:0] == 2'h3
    |-> ##2 src_prio[11:0] == pk($past(pwdata, 2))) else $error("group4 write");
  AST_RSV: assert property (psel && penable && !pwrite && paddr == 12'h000
    |-> prdata[31:4] == 28'h0 && !prdata[0]) else $error("reserved bits");
  COV_WR: cover property (wr && paddr == iep_pkg::IEP_OFS_ENABLE_GROUP4);
  COV_ERR: cover property (psel && penable && pslverr);
  COV_ACT: cover property (src_active != 17'h0);
endmodule // iep_slice_monitor

bind iep_slice iep_slice_monitor iep_slice_monitor_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .en4_req(en4_req), .en4_bits(en4_bits), .en4_req_gated(en4_req_gated),
  .src_en(src_en), .src_req(src_req), .src_prio(src_prio), .src_active(src_active));

// ===== tb/iep_src_model.sv
// Model of the peripheral sources and foreign enables beside the slice.
// Assumes the bench commands patterns; requests are levels on pclk.
`timescale 1ns/1ps
module iep_src_model (
  input  wire logic              pclk,    // Clock.
  input  wire logic              presetn, // Reset, active low.
  input  wire logic [2:0]        cmd_en4, // Wanted group-four requests.
  input  wire iep_pkg::iep_src_t cmd_req, // Wanted requests.
  input  wire iep_pkg::iep_src_t cmd_en,  // Wanted enables.
  output logic      [2:0]        en4_req, // Group-four requests.
  output iep_pkg::iep_src_t      src_req, // Requests.
  output iep_pkg::iep_src_t      src_en   // Enables.
);
  // Peripherals are held in reset too, so their requests drop with it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en4_req <= 3'h0;
      src_req <= '0;
      src_en  <= '0;
    end else begin
      en4_req <= cmd_en4;
      src_req <= cmd_req;
      src_en  <= cmd_en;
    end
  end
endmodule // iep_src_model

// ===== tb/tb_top.sv
// Self-checking bench for the enable and priority slice.
// Drives APB as master; the source model feeds the request side.
`timescale 1ns/1ps
module tb_top;
  localparam logic [15:0] RST_V [6] = '{16'h0000, 16'h4444, 16'h4440, 16'h4444, 16'h0044,
    16'h4444};
  localparam logic [15:0] MSK_V [6] = '{16'h000e, 16'h7777, 16'h7770, 16'h7777, 16'h0077,
    16'h7777};
  logic               pclk    = 1'b0;
  logic               presetn = 1'b0;
  logic               psel    = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite  = 1'b0;
  logic [11:0]        paddr   = 12'h000;
  logic [31:0]        pwdata  = 32'h0;
  logic [3:0]         pstrb   = 4'h0;
  logic [2:0]         cmd_en4 = 3'h0;
  iep_pkg::iep_src_t  cmd_req = '0;
  iep_pkg::iep_src_t  cmd_en  = '0;
  logic [31:0]        prdata, rd;
  logic               pready, pslverr, er;
  logic [2:0]         en4_req, en4_req_gated;
  iep_pkg::iep_en4_t  en4_bits;
  iep_pkg::iep_src_t  src_en, src_req, src_active;
  iep_pkg::iep_prio_t src_prio;
  int                 err_total = 0;
  int                 n_tests   = 0;
  // Clock at 40 MHz.
  always #12.5 pclk = ~pclk;
  iep_slice iep_slice_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .en4_req(en4_req), .en4_bits(en4_bits),
    .en4_req_gated(en4_req_gated), .src_en(src_en), .src_req(src_req),
    .src_prio(src_prio), .src_active(src_active));
  iep_src_model iep_src_model_inst (.pclk(pclk), .presetn(presetn), .cmd_en4(cmd_en4),
    .cmd_req(cmd_req), .cmd_en(cmd_en), .en4_req(en4_req), .src_req(src_req), .src_en(src_en));
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One transfer; waits on pready under a bound, result left in rd and er.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) err_total++;
  endtask
  // Lets k edges land, then samples away from the edge.
  task automatic tick(input int k);
    repeat (k) @(posedge pclk);
    @(negedge pclk);
  endtask
  task automatic rst();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  task automatic t_reset();
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 12'(4 * i), 32'h0, 4'h0);
      chk("reset value", rd, {16'h0, RST_V[i]});
    end
    chk("reset levels", src_prio, {17{3'h4}});
    $display("test reset done");
  endtask
  task automatic t_masks();
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, 12'(4 * i), 32'hffffffff, 4'hf);
      apb(1'b0, 12'(4 * i), 32'h0, 4'h0);
      chk("ones readback", rd, {16'h0, MSK_V[i]});
      apb(1'b1, 12'(4 * i), 32'h0, 4'hf);
      apb(1'b0, 12'(4 * i), 32'h0, 4'h0);
      chk("zero readback", rd, 32'h0);
    end
    $display("test masks done");
  endtask
  task automatic t_fields();
    apb(1'b1, 12'h004, 32'h7531, 4'hf);
    apb(1'b1, 12'h008, 32'h7655, 4'hf);
    apb(1'b0, 12'h008, 32'h0, 4'h0);
    chk("group1 read", rd, 32'h7650);
    apb(1'b1, 12'h00c, 32'h1357, 4'hf);
    apb(1'b1, 12'h010, 32'hff32, 4'hf);
    apb(1'b0, 12'h010, 32'h0, 4'h0);
    chk("group3 read", rd, 32'h0032);
    apb(1'b1, 12'h014, 32'h2460, 4'hf);
    tick(1);
    chk("group0 levels", src_prio[50:39], {3'h7, 3'h5, 3'h3, 3'h1});
    chk("group1 levels", src_prio[38:30], {3'h7, 3'h6, 3'h5});
    chk("group2 levels", src_prio[29:18], {3'h1, 3'h3, 3'h5, 3'h7});
    chk("group3 levels", src_prio[17:12], {3'h3, 3'h2});
    chk("group4 levels", src_prio[11:0], {3'h2, 3'h4, 3'h6, 3'h0});
    $display("test fields done");
  endtask
  task automatic t_gate();
    apb(1'b1, 12'h000, 32'h8, 4'h1);
    @(posedge pclk) cmd_en4 <= 3'h7;
    tick(3);
    chk("enables", en4_bits, 3'h4);
    chk("gated", en4_req_gated, 3'h4);
    apb(1'b1, 12'h000, 32'h6, 4'h1);
    tick(1);
    chk("gated", en4_req_gated, 3'h3);
    chk("enables", en4_bits, 3'h3);
    $display("test gate done");
  endtask
  task automatic t_active();
    @(posedge pclk);
    cmd_req <= '1;
    cmd_en  <= '1;
    tick(3);
    chk("active", src_active, 17'h1fffe);
    @(posedge pclk) cmd_en <= '0;
    tick(3);
    chk("active off", src_active, 17'h0);
    $display("test active done");
  endtask
  task automatic t_refuse();
    apb(1'b0, 12'h018, 32'h0, 4'h0);
    chk("unmapped err", er, 1'b1);
    chk("unmapped data", rd, 32'h0);
    apb(1'b1, 12'h006, 32'hffffffff, 4'hf);
    chk("misaligned err", er, 1'b1);
    apb(1'b1, 12'h004, 32'h0, 4'h1);
    apb(1'b0, 12'h004, 32'h0, 4'h0);
    chk("lane write", rd, 32'h7500);
    chk("mapped err", er, 1'b0);
    $display("test refuse done");
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Run takes near 200 cycles; the watchdog allows four times that.
  initial begin
    #20000;
    err_total++;
    results();
  end
  initial begin
    rst();
    t_reset();
    t_masks();
    t_fields();
    t_gate();
    t_active();
    t_refuse();
    rst();
    t_reset();
    results();
  end
endmodule // tb_top
